/* File: rtl/csm_merger.sv */
// Command source merger: combines terminal and serial command bits.
// Assumes terminal bits come from pins (synchronised here) and APB on pclk.
// Functional notes
// - Start follows selected source, AND or OR
// - Reverse anticlockwise by same four-mode merge
// - Serial setup pair decodes binary plus one
// - Terminal setup pair alone, serial ignored
// - AND/OR of setup pairs, plus one
// - Serial preset honoured only in native profile
// - Selector codes 0..3, OR is default
// - Preset and setup use same four modes
// - Serial jog only in fieldbus profile
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module csm_merger
  import csm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminal inputs
  input wire logic term_start,
  input wire logic term_reverse,
  input wire logic [1:0] term_setup,
  input wire logic [1:0] term_preset,
  // Merged commands
  output logic cmd_start,
  output logic cmd_reverse,
  output logic [2:0] cmd_setup,
  output logic [1:0] cmd_preset,
  output logic cmd_jog_one,
  output logic cmd_jog_two
);

  // Register map, byte offsets, one word each
  //   0x00 selectors: start, reverse, setup, preset, profile
  //   0x04 serial control word
  //   0x08 jog speed one, tenths of hertz
  //   0x0c jog speed two, tenths of hertz
  //   0x10 merged commands, read only
  //   0x14 output frequency high limit
  // Upper bits unused, read as zero
  // Selector fields, two bits each
  //   [1:0] start, [3:2] reverse
  //   [5:4] setup, [7:6] preset
  //   [9:8] profile: 0 fieldbus, 1 native
  // Control word bits
  //   [0] start, [1] reverse
  //   [3:2] setup pair, msb first
  //   [5:4] preset pair
  //   [6] jog one, [7] jog two
  // Bus timing
  //   Offset decoded on first access edge
  //   Read data and refusal stand with pready
  //   Write stored only where pready is sampled
  // Command timing
  //   Pin change: three edges to the outputs
  //   Stored word: one edge to the outputs
  // Profile gating
  //   Serial preset bits zero outside native profile
  //   Jog requests only in fieldbus profile
  //   Other profile codes enable neither
  // Limits
  //   Jog writes clamp down to the limit
  //   Lowering the limit clamps stored jogs
  //   Raising it leaves jogs unchanged

  // All state of the block in one register
  typedef struct packed {
    // Two-stage pin synchroniser
    logic [5:0] sync1;
    logic [5:0] sync2;
    // Source selectors and telegram profile
    logic [1:0] sel_start;
    logic [1:0] sel_rev;
    logic [1:0] sel_setup;
    logic [1:0] sel_preset;
    logic [1:0] profile;
    // Serial control word
    logic [7:0] ctrl;
    // Jog speeds and high limit, tenths of hertz
    logic [15:0] jog1;
    logic [15:0] jog2;
    logic [15:0] fmax;
    // Bus answer, one cycle
    logic [31:0] rdata;
    logic ready;
    logic err;
    // Merged command outputs
    logic start;
    logic rev;
    logic [2:0] setup;
    logic [1:0] preset;
    logic jog_one;
    logic jog_two;
  } csm_state_t;

  csm_state_t state_reg;
  csm_state_t state_next;

  // Merge one bit under a selector code
  function automatic logic csm_merge(input logic [1:0] sel, input logic t, input logic s);
    unique case (sel)
      CSM_SRC_TERM: csm_merge = t;
      CSM_SRC_SER: csm_merge = s;
      CSM_SRC_AND: csm_merge = t & s;
      CSM_SRC_OR: csm_merge = t | s;
    endcase
  endfunction

  // Clamp a jog setting to the high limit
  function automatic logic [15:0] csm_clamp(input logic [15:0] v, input logic [15:0] lim);
    csm_clamp = (v > lim) ? lim : v;
  endfunction

  // Setup and preset pairs: terminal, serial, merged
  logic [1:0] t_setup;
  logic [1:0] s_setup;
  logic [1:0] m_setup;
  logic [1:0] t_pre;
  logic [1:0] s_pre;
  logic [1:0] m_pre;
  // Bus phase decode
  logic access;
  logic wr;

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = {term_preset, term_setup, term_reverse, term_start};
    state_next.sync2 = state_reg.sync1;
    // First access cycle: pready not yet raised
    access = psel & penable & ~state_reg.ready;
    // Commit edge: master samples pready high
    wr = psel & penable & state_reg.ready & pwrite;
    state_next.ready = access;
    state_next.err = 1'b0;
    state_next.rdata = 32'h0000_0000;

    // Write refusal decided early, stands with pready
    if (access & pwrite)
    begin
      state_next.err = ~(paddr inside {CSM_OFS_SEL, CSM_OFS_CTRL,
                                       CSM_OFS_JOG1, CSM_OFS_JOG2, CSM_OFS_FMAX});
    end

    // Register writes, stored at the commit edge only
    if (wr)
    begin
      unique case (paddr)
        CSM_OFS_SEL:
        begin
          state_next.sel_start = pwdata[CSM_SEL_START_POS +: 2];
          state_next.sel_rev = pwdata[CSM_SEL_REV_POS +: 2];
          state_next.sel_setup = pwdata[CSM_SEL_SETUP_POS +: 2];
          state_next.sel_preset = pwdata[CSM_SEL_PRESET_POS +: 2];
          state_next.profile = pwdata[CSM_SEL_PROF_POS +: 2];
        end
        CSM_OFS_CTRL:
        begin
          state_next.ctrl = pwdata[7:0];
        end
        CSM_OFS_JOG1:
        begin
          state_next.jog1 = csm_clamp(pwdata[15:0], state_reg.fmax);
        end
        CSM_OFS_JOG2:
        begin
          state_next.jog2 = csm_clamp(pwdata[15:0], state_reg.fmax);
        end
        CSM_OFS_FMAX:
        begin
          // Lower limit pulls stored jogs down
          state_next.fmax = pwdata[15:0];
          state_next.jog1 = csm_clamp(state_reg.jog1, pwdata[15:0]);
          state_next.jog2 = csm_clamp(state_reg.jog2, pwdata[15:0]);
        end
        default:
        begin
          // Refused in the access cycle, nothing stored
        end
      endcase
    end

    // Register reads, registered to stand with pready
    if (access & ~pwrite)
    begin
      unique case (paddr)
        CSM_OFS_SEL:
        begin
          state_next.rdata = {22'h0, state_reg.profile, state_reg.sel_preset,
                              state_reg.sel_setup, state_reg.sel_rev,
                              state_reg.sel_start};
        end
        CSM_OFS_CTRL:
        begin
          state_next.rdata = {24'h0, state_reg.ctrl};
        end
        CSM_OFS_JOG1:
        begin
          state_next.rdata = {16'h0, state_reg.jog1};
        end
        CSM_OFS_JOG2:
        begin
          state_next.rdata = {16'h0, state_reg.jog2};
        end
        CSM_OFS_FMAX:
        begin
          state_next.rdata = {16'h0, state_reg.fmax};
        end
        CSM_OFS_STAT:
        begin
          // Merged commands as now driven
          state_next.rdata = {23'h0, state_reg.jog_two, state_reg.jog_one,
                              state_reg.preset, state_reg.setup,
                              state_reg.rev, state_reg.start};
        end
        default:
        begin
          state_next.err = 1'b1;
        end
      endcase
    end

    // Start and reverse: one bit each, four-mode merge
    state_next.start = csm_merge(state_reg.sel_start, state_reg.sync2[0],
                                 state_reg.ctrl[CSM_CW_START_POS]);
    state_next.rev = csm_merge(state_reg.sel_rev, state_reg.sync2[1],
                               state_reg.ctrl[CSM_CW_REV_POS]);

    // Setup pair: merged bitwise, then plus one
    t_setup = state_reg.sync2[3:2];
    s_setup = state_reg.ctrl[CSM_CW_SETUP_POS +: 2];
    unique case (state_reg.sel_setup)
      CSM_SRC_TERM: m_setup = t_setup;
      CSM_SRC_SER: m_setup = s_setup;
      CSM_SRC_AND: m_setup = t_setup & s_setup;
      CSM_SRC_OR: m_setup = t_setup | s_setup;
    endcase
    state_next.setup = {1'b0, m_setup} + 3'h1;

    // Preset pair
    t_pre = state_reg.sync2[5:4];
    // Serial preset bits count only in native profile
    s_pre = (state_reg.profile == CSM_PROF_NATIVE) ?
            state_reg.ctrl[CSM_CW_PRESET_POS +: 2] : 2'h0;
    unique case (state_reg.sel_preset)
      CSM_SRC_TERM: m_pre = t_pre;
      CSM_SRC_SER: m_pre = s_pre;
      CSM_SRC_AND: m_pre = t_pre & s_pre;
      CSM_SRC_OR: m_pre = t_pre | s_pre;
    endcase
    state_next.preset = m_pre;

    // Jog selection only in fieldbus profile
    state_next.jog_one = (state_reg.profile == CSM_PROF_FIELDBUS) &
                         state_reg.ctrl[CSM_CW_JOG1_POS];
    state_next.jog_two = (state_reg.profile == CSM_PROF_FIELDBUS) &
                         state_reg.ctrl[CSM_CW_JOG2_POS];
  end

  // State register with defaults at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      // Selectors default to OR, profile to native
      state_reg.sel_start <= CSM_SRC_OR;
      state_reg.sel_rev <= CSM_SRC_OR;
      state_reg.sel_setup <= CSM_SRC_OR;
      state_reg.sel_preset <= CSM_SRC_OR;
      state_reg.profile <= CSM_PROF_RESET;
      state_reg.jog1 <= CSM_JOG_RESET;
      state_reg.jog2 <= CSM_JOG_RESET;
      state_reg.fmax <= CSM_FMAX_RESET;
      state_reg.setup <= 3'h1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign cmd_start = state_reg.start;
  assign cmd_reverse = state_reg.rev;
  assign cmd_setup = state_reg.setup;
  assign cmd_preset = state_reg.preset;
  assign cmd_jog_one = state_reg.jog_one;
  assign cmd_jog_two = state_reg.jog_two;

endmodule

/* File: rtl/csm_pkg.sv */
// Package for the command source merger: register map, selector codes, defaults.
// Assumes a 32-bit APB slave with byte addresses on word boundaries.
package csm_pkg;
  // Source selector codes
  localparam logic [1:0] CSM_SRC_TERM = 2'h0;
  localparam logic [1:0] CSM_SRC_SER = 2'h1;
  localparam logic [1:0] CSM_SRC_AND = 2'h2;
  localparam logic [1:0] CSM_SRC_OR = 2'h3;
  // Telegram profile codes
  localparam logic [1:0] CSM_PROF_FIELDBUS = 2'h0;
  localparam logic [1:0] CSM_PROF_NATIVE = 2'h1;
  localparam logic [1:0] CSM_PROF_RESET = 2'h1;
  // Register byte offsets
  localparam logic [7:0] CSM_OFS_SEL = 8'h00;
  localparam logic [7:0] CSM_OFS_CTRL = 8'h04;
  localparam logic [7:0] CSM_OFS_JOG1 = 8'h08;
  localparam logic [7:0] CSM_OFS_JOG2 = 8'h0c;
  localparam logic [7:0] CSM_OFS_STAT = 8'h10;
  localparam logic [7:0] CSM_OFS_FMAX = 8'h14;
  // Selector register fields
  localparam int CSM_SEL_START_POS = 0;
  localparam int CSM_SEL_REV_POS = 2;
  localparam int CSM_SEL_SETUP_POS = 4;
  localparam int CSM_SEL_PRESET_POS = 6;
  localparam int CSM_SEL_PROF_POS = 8;
  // Control word fields written by the serial master
  localparam int CSM_CW_START_POS = 0;
  localparam int CSM_CW_REV_POS = 1;
  localparam int CSM_CW_SETUP_POS = 2;
  localparam int CSM_CW_PRESET_POS = 4;
  localparam int CSM_CW_JOG1_POS = 6;
  localparam int CSM_CW_JOG2_POS = 7;
  // Frequencies in tenths of hertz
  localparam logic [15:0] CSM_JOG_RESET = 16'h0064;
  localparam logic [15:0] CSM_FMAX_RESET = 16'h01f4;
endpackage

/* File: verif/csm_merger_monitor.sv */
// Checker for the command merger, bound to its top module.
// Assumes commands follow writes by one edge and pins by three.
`timescale 1ns/1ps
module csm_merger_mon
  import csm_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Terminals and commands
  input wire logic term_start, term_reverse, cmd_start, cmd_reverse, cmd_jog_one, cmd_jog_two,
  input wire logic [1:0] term_setup, term_preset, cmd_preset,
  input wire logic [2:0] cmd_setup
);
  typedef struct packed {logic [9:0] sel; logic [7:0] ctrl; logic [5:0] t1; logic [5:0] t2;} csm_mon_t;
  csm_mon_t s_reg, s_next;
  logic wr;
  logic [5:0] e_cmd;
  logic [1:0] e_jog;
  logic [5:0] s_vec;
  logic [3:0][5:0] e_by;
  // Four-mode merge, bit by bit
  function automatic logic [5:0] mg(input logic [1:0] m, input logic [5:0] t, s);
    case (m)
      CSM_SRC_TERM: mg = t;
      CSM_SRC_SER: mg = s;
      CSM_SRC_AND: mg = t & s;
      default: mg = t | s;
    endcase
  endfunction
  // Shadow of selectors, control word and pin pipeline
  assign wr = psel && penable && pready && pwrite && !pslverr;
  always_comb
  begin
    s_next = s_reg;
    s_next.t1 = {term_preset, term_setup, term_reverse, term_start};
    s_next.t2 = s_reg.t1;
    if (wr && paddr == CSM_OFS_SEL) s_next.sel = pwdata[9:0];
    if (wr && paddr == CSM_OFS_CTRL) s_next.ctrl = pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) s_reg <= '{sel: 10'h1ff, default: '0};
    else s_reg <= s_next;
  end
  // Expected merges; serial preset needs native, jog fieldbus
  assign s_vec = {s_reg.ctrl[5:4] & {2{s_reg.sel[9:8] == CSM_PROF_NATIVE}}, s_reg.ctrl[3:0]};
  for (genvar i = 0; i < 4; i++)
  begin : g_field
    assign e_by[i] = mg(s_reg.sel[2*i +: 2], s_reg.t2, s_vec);
  end
  assign e_cmd = {e_by[3][5:4], e_by[2][3:2], e_by[1][1], e_by[0][0]};
  assign e_jog = s_reg.ctrl[7:6] & {2{s_reg.sel[9:8] == CSM_PROF_FIELDBUS}};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_start_merge: assert property (cmd_start == $past(e_cmd[0]))
    else $error("start differs from merge");
  a_reverse_merge: assert property (cmd_reverse == $past(e_cmd[1]))
    else $error("direction differs from merge");
  a_setup_merge: assert property (cmd_setup == {1'b0, $past(e_cmd[3:2])} + 3'h1)
    else $error("setup differs from merge");
  a_setup_range: assert property (cmd_setup inside {[3'h1:3'h4]})
    else $error("setup out of range");
  a_preset_merge: assert property (cmd_preset == $past(e_cmd[5:4]))
    else $error("preset differs from merge");
  a_jog_gate: assert property ({cmd_jog_two, cmd_jog_one} == $past(e_jog))
    else $error("jog differs from gate");
  a_jog_profile: assert property (cmd_jog_one |-> $past(s_reg.sel[9:8]) == CSM_PROF_FIELDBUS)
    else $error("jog outside fieldbus");
  a_reset_load: assert property (disable iff (1'b0) !presetn |-> cmd_setup == 3'h1 && !cmd_start)
    else $error("reset outputs wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  // Main scenarios reached
  cover property (cmd_start && s_reg.sel[1:0] == CSM_SRC_AND);
  cover property (cmd_jog_one);
  cover property (pslverr);
endmodule
bind csm_merger csm_merger_mon i_mon (.*);

/* File: verif/csm_merger_tb.sv */
// Bench for the command merger: APB tests with expected values.
// Assumes the serial master model and the bound checker.
`timescale 1ns/1ps
module csm_merger_tb
  import csm_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b1, term_start = 1'b0, term_reverse = 1'b0, e;
  logic psel, penable, pwrite, pready, pslverr, cmd_start, cmd_reverse, cmd_jog_one, cmd_jog_two;
  logic [1:0] term_setup = 2'h0, term_preset = 2'h0, cmd_preset;
  logic [2:0] cmd_setup;
  logic [5:0] x;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  always #50 pclk = ~pclk;
  csm_merger i_dut (.*);
  csm_serial_master i_mst (.*);
  // Compare and count
  task automatic chk(input logic [32:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_mst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    i_mst.xfer(1'b0, a, 32'h0, q, e);
    chk({e, q}, {1'b0, d});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [5:0] mg(input logic [1:0] m, input logic [5:0] t, s);
    mg = (m == 2'h0) ? t : (m == 2'h1) ? s : (m == 2'h2) ? (t & s) : (t | s);
  endfunction
  // Hang limit
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      end_sim();
    end
  end
  // Test sequence
  initial
  begin
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(CSM_OFS_SEL, 32'h1ff);
    rd(CSM_OFS_JOG2, 32'h64);
    rd(CSM_OFS_STAT, 32'h4);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
      for (int v = 0; v < 16; v++)
      begin
        wr(CSM_OFS_SEL, {22'h0, CSM_PROF_NATIVE, {4{m[1:0]}}});
        wr(CSM_OFS_CTRL, {26'h0, v[3:2], v[3:2], v[3], v[2]});
        term_start <= v[0];
        term_reverse <= v[1];
        term_setup <= v[1:0];
        term_preset <= v[1:0];
        x = mg(m[1:0], {v[1:0], v[1:0], v[1:0]}, {v[3:2], v[3:2], v[3:2]});
        repeat (4) @(posedge pclk);
        chk({cmd_preset, cmd_setup, cmd_reverse, cmd_start}, {x[5:4], {1'b0, x[3:2]} + 3'h1, x[1], x[0]});
      end
    $display("test merge done");
    term_preset <= 2'h0;
    for (int p = 0; p < 2; p++)
    begin
      wr(CSM_OFS_SEL, {22'h0, p[1:0], 8'h55});
      wr(CSM_OFS_CTRL, 32'hf0);
      repeat (2) @(posedge pclk);
      chk({cmd_jog_two, cmd_jog_one, cmd_preset}, (p == 1) ? 33'h3 : 33'hc);
    end
    $display("test profile done");
    wr(CSM_OFS_JOG1, 32'hffff);
    rd(CSM_OFS_JOG1, 32'h1f4);
    wr(CSM_OFS_JOG2, 32'h0);
    rd(CSM_OFS_JOG2, 32'h0);
    wr(CSM_OFS_FMAX, 32'h32);
    rd(CSM_OFS_FMAX, 32'h32);
    rd(CSM_OFS_JOG1, 32'h32);
    i_mst.xfer(1'b0, 8'h18, 32'h0, q, e);
    chk(e, 33'h1);
    i_mst.xfer(1'b1, CSM_OFS_STAT, 32'h0, q, e);
    chk(e, 33'h1);
    $display("test limits done");
    end_sim();
  end
endmodule

/* File: verif/csm_serial_master.sv */
// Serial master model: sends control words over APB.
// Assumes one pclk domain; the bench calls xfer hierarchically.
`timescale 1ns/1ps
module csm_serial_master
(
  // APB master
  input wire logic pclk, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
